// ### core/abscfg_top.sv
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "abscfg_cfg.svh"

module abscfg_top (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic [3:0]  resSel0,
    input  wire logic [3:0]  fmtSel0,
    input  wire logic [3:0]  resSel1,
    input  wire logic [3:0]  fmtSel1,
    input  wire logic [1:0]  strobe,
    input  wire logic [31:0] rawPos0,
    input  wire logic [31:0] rawPos1,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic [1:0]       quadA,
    output logic [1:0]       quadB,
    output logic [1:0]       relayOk,
    output logic [1:0]       cfgFault,
    output logic [1:0]       sampleReq,
    output logic [1:0]       multiTurn,
    output logic [1:0]       freeRun,
    output logic [63:0]      resMaskOut,
    output logic             irq
);

    // -----------------------------------------------------------
    // Decode helpers
    // -----------------------------------------------------------
    // Resolution in bits per turn
    function automatic logic [4:0] resBits(input logic [3:0] code);
        case (code)
            4'hC:    resBits = 5'h15;
            4'hD:    resBits = 5'h16;
            4'hE:    resBits = 5'h18;
            4'hF:    resBits = 5'h19;
            default: resBits = 5'h07 + {1'b0, code};
        endcase
    endfunction

    function automatic logic [31:0] gray2bin(input logic [31:0] g);
        logic [31:0] b;
        b = g;
        for (int i = 30; i >= 0; i--) begin
            b[i] = b[i + 1] ^ g[i];
        end
        gray2bin = b;
    endfunction

    // Position masked to the configured resolution
    function automatic logic [31:0] resMask(input logic [4:0] bits);
        resMask = (32'h0000_0001 << bits) - 32'h0000_0001;
    endfunction

    typedef struct packed {
        logic [1:0][3:0]  res;
        logic [1:0][3:0]  fmt;
        logic             cfgDone;
        logic [1:0][31:0] lastPos;
        logic [1:0][31:0] delta;
        logic [1:0]       load;
        logic [1:0]       primed;
        logic [1:0]       strobeD;
        logic [14:0]      msCnt;
        logic [2:0]       edgeCnt;
        logic [3:0]       status;
        logic [3:0]       mask;
        logic [1:0]       enable;
        logic [31:0]      rdata;
    } abscfg_st_t;

    abscfg_st_t cur;
    abscfg_st_t next_cur;

    logic [1:0]  invalid;
    logic [1:0]  trig;
    logic [1:0]  busy;
    logic        msTick;
    logic        edgeTick;
    logic        wrAcc;
    logic [31:0] pos [2];

    // -----------------------------------------------------------
    // Per-axis decode, each flag from one bit of the format value
    // -----------------------------------------------------------
    always_comb begin
        for (int a = 0; a < 2; a++) begin
            invalid[a]   = cur.fmt[a][0];
            multiTurn[a] = cur.fmt[a][3];
            freeRun[a]   = cur.fmt[a][1];
            resMaskOut[a*32 +: 32] = resMask(resBits(cur.res[a]));
        end
    end

    assign pos[0] = (cur.fmt[0][2] ? rawPos0 : gray2bin(rawPos0))
                    & resMaskOut[31:0];
    assign pos[1] = (cur.fmt[1][2] ? rawPos1 : gray2bin(rawPos1))
                    & resMaskOut[63:32];

    assign msTick   = (cur.msCnt == 15'(`ABSCFG_UPD_CYC - 1));
    assign edgeTick = (cur.edgeCnt == 3'(`ABSCFG_EDGE_CYC - 1));
    assign wrAcc    = psel && penable && pwrite;

    // Update triggers: 1 ms timebase or strobe rising edge
    always_comb begin
        for (int a = 0; a < 2; a++) begin
            trig[a] = freeRun[a] ? msTick
                                 : (strobe[a] && !cur.strobeD[a]);
        end
    end

    // -----------------------------------------------------------
    // Next-state logic
    // -----------------------------------------------------------
    always_comb begin
        next_cur = cur;
        next_cur.load    = 2'b00;
        next_cur.strobeD = strobe;
        next_cur.msCnt   = msTick ? 15'h0000 : cur.msCnt + 15'h0001;
        next_cur.edgeCnt = edgeTick ? 3'h0 : cur.edgeCnt + 3'h1;
        // Strap capture once, after reset release
        if (!cur.cfgDone) begin
            next_cur.res[0]  = resSel0;
            next_cur.fmt[0]  = fmtSel0;
            next_cur.res[1]  = resSel1;
            next_cur.fmt[1]  = fmtSel1;
            next_cur.cfgDone = 1'b1;
        end
        // Software clears status with ones; hardware set wins
        if (wrAcc && paddr == `ABSCFG_OFS_STATUS) begin
            next_cur.status = cur.status & ~pwdata[3:0];
        end
        if (wrAcc && paddr == `ABSCFG_OFS_MASK) begin
            next_cur.mask = pwdata[3:0];
        end
        if (wrAcc && paddr == `ABSCFG_OFS_CTRL) begin
            next_cur.enable = pwdata[1:0];
        end
        for (int a = 0; a < 2; a++) begin
            if (cur.cfgDone && invalid[a]) begin
                next_cur.status[`ABSCFG_ST_FAULT + a] = 1'b1;
            end
            // Skip new samples while the previous delta still streams
            if (cur.cfgDone && trig[a] && !busy[a] && cur.enable[a]) begin
                next_cur.lastPos[a] = pos[a];
                next_cur.primed[a]  = 1'b1;
                // First sample only sets the reference, no jump at start
                next_cur.delta[a] = cur.primed[a] ? pos[a] - cur.lastPos[a]
                                                  : 32'h0000_0000;
                next_cur.load[a]  = 1'b1;
                next_cur.status[`ABSCFG_ST_UPDATE + a] = 1'b1;
            end
        end
        // Read data registered at the setup cycle
        case (paddr)
            `ABSCFG_OFS_STATUS:  next_cur.rdata = {28'h0, cur.status};
            `ABSCFG_OFS_MASK:    next_cur.rdata = {28'h0, cur.mask};
            `ABSCFG_OFS_CONFIG0: next_cur.rdata = {24'h0, cur.fmt[0],
                                                  cur.res[0]};
            `ABSCFG_OFS_CONFIG1: next_cur.rdata = {24'h0, cur.fmt[1],
                                                  cur.res[1]};
            `ABSCFG_OFS_DELTA0:  next_cur.rdata = cur.delta[0];
            `ABSCFG_OFS_DELTA1:  next_cur.rdata = cur.delta[1];
            `ABSCFG_OFS_CTRL:    next_cur.rdata = {30'h0, cur.enable};
            default:             next_cur.rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            cur.res     <= '0;
            cur.fmt     <= '0;
            cur.cfgDone <= 1'b0;
            cur.lastPos <= '0;
            cur.delta   <= '0;
            cur.load    <= 2'b00;
            cur.primed  <= 2'b00;
            cur.strobeD <= 2'b00;
            cur.msCnt   <= 15'h0000;
            cur.edgeCnt <= 3'h0;
            cur.status  <= 4'h0;
            cur.mask    <= `ABSCFG_MASK_RST;
            cur.enable  <= `ABSCFG_CTRL_RST;
            cur.rdata   <= 32'h0000_0000;
        end else begin
            cur <= next_cur;
        end
    end

    // -----------------------------------------------------------
    // Bus and outputs
    // -----------------------------------------------------------
    // Zero wait states: setup fetches the data, access returns it
    assign prdata    = cur.rdata;
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && (paddr[11:5] != 7'h00
                       || paddr[4:2] == 3'h7 || paddr[1:0] != 2'h0);
    assign irq       = |(cur.status & cur.mask);
    assign sampleReq = cur.load;
    assign cfgFault  = invalid & {2{cur.cfgDone}};
    assign relayOk   = ~invalid & {2{cur.cfgDone}};

    // Axis quadrature emitters
    for (genvar a = 0; a < 2; a++) begin : gAxis
        abscfg_axis uAxis (
            .core_clk (core_clk),
            .rst_b    (rst_b),
            .edgeTick (edgeTick),
            .inhibit  (cfgFault[a]),
            .load     (cur.load[a]),
            .delta    (cur.delta[a]),
            .quadA    (quadA[a]),
            .quadB    (quadB[a]),
            .busy     (busy[a])
        );
    end

    // -----------------------------------------------------------
    // Checks
    // -----------------------------------------------------------
    straps_frozen_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        $past(cur.cfgDone) |-> $stable(cur.fmt) && $stable(cur.res))
        else $error("captured selectors changed after start");

    odd_code_faults_a: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        cur.cfgDone && cur.fmt[0][0] |-> cfgFault[0] && !relayOk[0])
        else $error("odd format code did not raise fault");

    ms_period_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        msTick |=> !msTick [*8])
        else $error("timebase ticked too early");

    // Cycles since the last tick, kept apart from the divider itself;
    // a counter, since a 1 ms delay range is far too long to unroll
    logic [14:0] msGap;

    always_ff @(posedge core_clk) begin
        if (!rst_b || msTick) begin
            msGap <= 15'h0000;
        end else begin
            msGap <= msGap + 15'h0001;
        end
    end

    ms_bound_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        msGap < 15'(`ABSCFG_UPD_CYC))
        else $error("1 ms timebase did not repeat");

    lock_follows_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        cur.cfgDone && !cur.fmt[1][1] && msTick && !strobe[1]
        |-> !trig[1])
        else $error("locked axis triggered without strobe");

    // Update: a trigger taken on an idle, enabled axis, then one pulse
    sequence updTaken;
        cur.cfgDone && trig[0] && !busy[0] && cur.enable[0];
    endsequence
    sequence updPulse;
        sampleReq[0] ##1 !sampleReq[0];
    endsequence
    upd_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        updTaken |=> updPulse)
        else $error("update trigger gave no single request pulse");

    res_top_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        cur.res[0] == 4'hF |-> resMaskOut[31:0] == 32'h01FF_FFFF)
        else $error("code F not 2^25 counts");

    res_c_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        cur.res[1] == 4'hC |-> resMaskOut[63:32] == 32'h001F_FFFF)
        else $error("code C not 2^21 counts");

    multi_turn_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        multiTurn[1] == (cur.fmt[1] >= 4'h8))
        else $error("turn type wrong for format");

    gray_conv_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        !cur.fmt[0][2] && rawPos0 == 32'h0000_0003
        |-> pos[0] == 32'h0000_0002)
        else $error("gray data not converted");

    irq_gate_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        irq == |(cur.status & cur.mask))
        else $error("interrupt not gated by mask");

endmodule // abscfg_top

// ### core/abscfg_cfg.svh
`ifndef ABSCFG_CFG_SVH
`define ABSCFG_CFG_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define ABSCFG_OFS_STATUS   12'h000
`define ABSCFG_OFS_MASK     12'h004
`define ABSCFG_OFS_CONFIG0  12'h008
`define ABSCFG_OFS_CONFIG1  12'h00C
`define ABSCFG_OFS_DELTA0   12'h010
`define ABSCFG_OFS_DELTA1   12'h014
`define ABSCFG_OFS_CTRL     12'h018

// ----------------------------------------------------------------
// Status bit positions (per axis: base + axis)
// ----------------------------------------------------------------
`define ABSCFG_ST_FAULT     0
`define ABSCFG_ST_UPDATE    2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ABSCFG_MASK_RST     4'h0
`define ABSCFG_CTRL_RST     2'h3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ABSCFG_CLK_HZ       20000000
`define ABSCFG_UPD_US       1000
`define ABSCFG_UPD_CYC      ((`ABSCFG_CLK_HZ / 1000000) * `ABSCFG_UPD_US)
`define ABSCFG_QUAD_HZ      800000
// Edge rate 4x channel frequency; rounded down, 6 cycles at these clock rates
`define ABSCFG_EDGE_CYC     (`ABSCFG_CLK_HZ / (4 * `ABSCFG_QUAD_HZ))

`endif

// ### core/abscfg_pkg.sv
package abscfg_pkg;

    // Turn type
    typedef enum logic {
        ABSCFG_SINGLE = 1'b0,
        ABSCFG_MULTI  = 1'b1
    } abscfg_turns_t;

    // Data code
    typedef enum logic {
        ABSCFG_GRAY   = 1'b0,
        ABSCFG_BINARY = 1'b1
    } abscfg_code_t;

    // Update mode
    typedef enum logic {
        ABSCFG_LOCKED  = 1'b0,
        ABSCFG_FREERUN = 1'b1
    } abscfg_mode_t;

    // Quadrature stepper states
    typedef enum logic [2:0] {
        ABSCFG_Q_IDLE  = 3'b001,
        ABSCFG_Q_STEP  = 3'b010,
        ABSCFG_Q_FAULT = 3'b100
    } abscfg_qstate_t;

endpackage

// ### core/abscfg_axis.sv
`timescale 1ns/1ps
`include "abscfg_cfg.svh"

// One axis: quadrature emitter of signed position deltas
module abscfg_axis (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        edgeTick,
    input  wire logic        inhibit,
    input  wire logic        load,
    input  wire logic [31:0] delta,
    output logic             quadA,
    output logic             quadB,
    output logic             busy
);

    typedef struct packed {
        abscfg_pkg::abscfg_qstate_t st;
        logic [31:0]                left;
        logic                       dirNeg;
        logic [1:0]                 phase;
    } abscfg_ax_t;

    abscfg_ax_t cur;
    abscfg_ax_t next_cur;

    // -----------------------------------------------------------
    // Stepper
    // -----------------------------------------------------------
    // Phase sequence 00,01,11,10 gives A leading B when counting up
    always_comb begin
        next_cur = cur;
        case (cur.st)
            abscfg_pkg::ABSCFG_Q_IDLE: begin
                if (inhibit) begin
                    next_cur.st = abscfg_pkg::ABSCFG_Q_FAULT;
                end else if (load && delta != 32'h0000_0000) begin
                    next_cur.dirNeg = delta[31];
                    next_cur.left   = delta[31] ? (32'h0000_0000 - delta)
                                                : delta;
                    next_cur.st     = abscfg_pkg::ABSCFG_Q_STEP;
                end
            end
            abscfg_pkg::ABSCFG_Q_STEP: begin
                if (inhibit) begin
                    next_cur.st = abscfg_pkg::ABSCFG_Q_FAULT;
                end else if (edgeTick) begin
                    // One count per edge of either channel
                    next_cur.phase = cur.dirNeg ? cur.phase - 2'h1
                                                : cur.phase + 2'h1;
                    next_cur.left  = cur.left - 32'h0000_0001;
                    if (cur.left == 32'h0000_0001) begin
                        next_cur.st = abscfg_pkg::ABSCFG_Q_IDLE;
                    end
                end
            end
            abscfg_pkg::ABSCFG_Q_FAULT: begin
                // Held until reset; pending counts are discarded
                next_cur.left = 32'h0000_0000;
            end
            default: begin
                next_cur.st = abscfg_pkg::ABSCFG_Q_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            cur.st     <= abscfg_pkg::ABSCFG_Q_IDLE;
            cur.left   <= 32'h0000_0000;
            cur.dirNeg <= 1'b0;
            cur.phase  <= 2'h0;
        end else begin
            cur <= next_cur;
        end
    end

    // Gray map of phase onto the channels
    assign quadA = cur.phase[1] ^ cur.phase[0];
    assign quadB = cur.phase[1];
    assign busy  = (cur.st == abscfg_pkg::ABSCFG_Q_STEP);

    // -----------------------------------------------------------
    // Checks
    // -----------------------------------------------------------
    fault_freezes_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        cur.st == abscfg_pkg::ABSCFG_Q_FAULT |=> $stable(cur.phase))
        else $error("quadrature moved while inhibited");

    sequence stepFwd;
        edgeTick && cur.st == abscfg_pkg::ABSCFG_Q_STEP && !cur.dirNeg
            && !inhibit;
    endsequence
    fwd_a_leads_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        stepFwd |=> cur.phase == $past(cur.phase) + 2'h1)
        else $error("forward step did not advance phase");

endmodule // abscfg_axis

// ### bench/abscfg_quad_rx.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Motion controller model: 4X quadrature decode per axis
// ------------------------------------------------------------
module abscfg_quad_rx (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic [1:0]  quadA,
    input  wire logic [1:0]  quadB,
    output logic      [31:0] pos0,
    output logic      [31:0] pos1,
    output logic      [15:0] gap0,
    output logic      [7:0]  badEdges
);
    logic [1:0]  prevA;
    logic [1:0]  prevB;
    logic [15:0] since0;
    logic [31:0] pos [2];

    // Counts exposed per axis
    assign pos0 = pos[0];
    assign pos1 = pos[1];

    // One count per edge; both channels moving at once means lost phase
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            prevA    <= 2'h0;
            prevB    <= 2'h0;
            since0   <= 16'h0;
            gap0     <= 16'h0;
            badEdges <= 8'h0;
            pos[0]   <= 32'h0;
            pos[1]   <= 32'h0;
        end else begin
            for (int k = 0; k < 2; k++) begin
                if (quadA[k] != prevA[k] && quadB[k] != prevB[k]) begin
                    badEdges <= badEdges + 8'h1;
                end else if (quadA[k] != prevA[k] ||
                             quadB[k] != prevB[k]) begin
                    if (quadA[k] ^ prevB[k]) begin
                        pos[k] <= pos[k] + 32'h1;
                    end else begin
                        pos[k] <= pos[k] - 32'h1;
                    end
                end
            end
            prevA <= quadA;
            prevB <= quadB;
            // Edge spacing on axis 0, kept to judge the channel rate
            if (quadA[0] != prevA[0] || quadB[0] != prevB[0]) begin
                gap0   <= since0 + 16'h1;
                since0 <= 16'h0;
            end else begin
                since0 <= since0 + 16'h1;
            end
        end
    end
endmodule // abscfg_quad_rx

// ### bench/absolute_encoder_axis_config_decode_tb.sv
`timescale 1ns/1ps
`include "abscfg_cfg.svh"

module absolute_encoder_axis_config_decode_tb;
    logic        core_clk;
    logic        rst_b;
    logic [3:0]  resSel0;
    logic [3:0]  fmtSel0;
    logic [3:0]  resSel1;
    logic [3:0]  fmtSel1;
    logic [1:0]  strobe;
    logic [31:0] rawPos0;
    logic [31:0] rawPos1;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  quadA;
    logic [1:0]  quadB;
    logic [1:0]  relayOk;
    logic [1:0]  cfgFault;
    logic [1:0]  sampleReq;
    logic [1:0]  multiTurn;
    logic [1:0]  freeRun;
    logic [63:0] resMaskOut;
    logic        irq;
    logic [31:0] pos0;
    logic [31:0] pos1;
    logic [15:0] gap0;
    logic [7:0]  badEdges;
    logic [31:0] rq;
    logic        re;
    logic [1:0]  s;
    int          n;
    int          num_errors;
    int          num_checks;

    abscfg_top uut (.core_clk(core_clk), .rst_b(rst_b), .resSel0(resSel0),
        .fmtSel0(fmtSel0), .resSel1(resSel1), .fmtSel1(fmtSel1),
        .strobe(strobe), .rawPos0(rawPos0), .rawPos1(rawPos1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .quadA(quadA), .quadB(quadB),
        .relayOk(relayOk), .cfgFault(cfgFault), .sampleReq(sampleReq),
        .multiTurn(multiTurn), .freeRun(freeRun),
        .resMaskOut(resMaskOut), .irq(irq));

    abscfg_quad_rx rx (.core_clk(core_clk), .rst_b(rst_b), .quadA(quadA),
        .quadB(quadB), .pos0(pos0), .pos1(pos1), .gap0(gap0),
        .badEdges(badEdges));

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task conclude;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task chk(input logic [63:0] seen, input logic [63:0] exp,
             input string what);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t %s seen %0h exp %0h", $time, what, seen, exp);
        end
    endtask

    // One APB transfer; request held until pready is seen high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            num_errors++;
            conclude();
        end
        rq = prdata;
        re = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Selectors are held across the capture edge after release
    task do_reset(input logic [3:0] f0, r0, f1, r1);
        @(posedge core_clk);
        rst_b   <= 1'b0;
        fmtSel0 <= f0;
        resSel0 <= r0;
        fmtSel1 <= f1;
        resSel1 <= r1;
        strobe  <= 2'h0;
        rawPos0 <= 32'h0;
        rawPos1 <= 32'h0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge core_clk);
    endtask

    // Strobe rise on the chosen axes, then time for the stream to finish
    task trig(input logic [1:0] m, output logic [1:0] seen);
        @(posedge core_clk);
        strobe <= 2'h0;
        @(posedge core_clk);
        strobe <= m;
        seen = 2'h0;
        repeat (8) begin
            @(posedge core_clk);
            seen |= sampleReq;
        end
        repeat (80) @(posedge core_clk);
    endtask

    task wait_req(output int cnt);
        cnt = 0;
        do begin
            @(posedge core_clk);
            cnt++;
        end while (sampleReq[0] !== 1'b1 && cnt < 21000);
        if (cnt >= 21000) begin
            num_errors++;
            conclude();
        end
    endtask

    function automatic int res_bits(input logic [3:0] r);
        if (r < 4'hC) return 7 + r;
        return (r == 4'hC) ? 21 : (r == 4'hD) ? 22 : (r == 4'hE) ? 24 : 25;
    endfunction

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Every selector code on both axes; later selector moves ignored
    task t_decode;
        logic [3:0]  f;
        logic [63:0] m;
        for (int c = 0; c < 16; c++) begin
            do_reset(c[3:0], c[3:0], ~c[3:0], ~c[3:0]);
            fmtSel0 <= ~c[3:0];
            resSel0 <= ~c[3:0];
            fmtSel1 <= c[3:0];
            resSel1 <= c[3:0];
            repeat (3) @(posedge core_clk);
            for (int ax = 0; ax < 2; ax++) begin
                f = ax ? ~c[3:0] : c[3:0];
                m = (64'h1 << res_bits(f)) - 64'h1;
                chk(cfgFault[ax], f[0], "fault flag");
                chk(relayOk[ax], !f[0], "relay");
                if (!f[0]) begin
                    chk(multiTurn[ax], f[3], "turns");
                    chk(freeRun[ax], f[1], "mode");
                end
                chk(resMaskOut[ax*32 +: 32], m[31:0], "res mask");
                apb(1'b0, 12'h008 + 12'h004 * ax, 32'h0);
                chk(rq[7:0], {f, f}, "config");
            end
        end
    endtask

    // Binary axis 0, Gray axis 1, both locked to the strobe
    task t_locked;
        do_reset(4'h4, 4'h5, 4'h0, 4'h5);
        trig(2'b11, s);
        chk(s, 2'b11, "locked req");
        rawPos0 <= 32'h5;
        rawPos1 <= 32'h2;
        trig(2'b11, s);
        chk(pos0, 32'h5, "pos0 up");
        chk(pos1, 32'h3, "gray pos1");
        chk(gap0, 16'h6, "edge gap");
        chk(badEdges, 8'h0, "phase");
        apb(1'b0, `ABSCFG_OFS_DELTA1, 32'h0);
        chk(rq, 32'h3, "delta1");
        rawPos0 <= 32'h2;
        trig(2'b01, s);
        chk(s, 2'b01, "one axis");
        chk(pos0, 32'h2, "pos0 down");
        chk(pos1, 32'h3, "pos1 kept");
        apb(1'b0, `ABSCFG_OFS_DELTA0, 32'h0);
        chk(rq, 32'hFFFFFFFD, "delta0");
    endtask

    // Registers, interrupt mask and clear, unmapped access, disable
    task t_regs;
        apb(1'b0, `ABSCFG_OFS_CTRL, 32'h0);
        chk(rq[1:0], 2'h3, "ctrl rst");
        apb(1'b0, `ABSCFG_OFS_MASK, 32'h0);
        chk(rq[3:0], 4'h0, "mask rst");
        chk(irq, 1'b0, "irq masked");
        apb(1'b0, `ABSCFG_OFS_STATUS, 32'h0);
        chk(rq[3:0], 4'hC, "status");
        apb(1'b1, `ABSCFG_OFS_MASK, 32'h4);
        @(posedge core_clk);
        chk(irq, 1'b1, "irq up");
        apb(1'b1, `ABSCFG_OFS_STATUS, 32'h4);
        apb(1'b0, `ABSCFG_OFS_STATUS, 32'h0);
        chk(rq[3:0], 4'h8, "w1c");
        chk(irq, 1'b0, "irq down");
        apb(1'b0, 12'h100, 32'h0);
        chk({re, rq}, {1'b1, 32'h0}, "unmapped");
        apb(1'b1, `ABSCFG_OFS_CTRL, 32'h2);
        trig(2'b11, s);
        chk(s, 2'b10, "axis disabled");
    endtask

    // Reserved format code: stream inhibited, fault keeps re-setting
    task t_fault;
        do_reset(4'h1, 4'h0, 4'h0, 4'h0);
        trig(2'b11, s);
        rawPos0 <= 32'h9;
        rawPos1 <= 32'h4;
        trig(2'b11, s);
        chk(pos0, 32'h0, "inhibited");
        chk(pos1, 32'h7, "healthy axis");
        chk(relayOk, 2'b10, "relay drop");
        apb(1'b1, `ABSCFG_OFS_STATUS, 32'h1);
        apb(1'b0, `ABSCFG_OFS_STATUS, 32'h0);
        chk(rq[0], 1'b1, "fault sticky");
    endtask

    // Free running Gray axis 0 beside a locked axis 1: own 1 ms timebase
    task t_free;
        do_reset(4'h2, 4'h0, 4'h4, 4'h0);
        wait_req(n);
        rawPos0 <= 32'h3;
        rawPos1 <= 32'h5;
        wait_req(n);
        chk(n, 20000, "tick period");
        repeat (40) @(posedge core_clk);
        chk(pos0, 32'h2, "free pos");
        chk(pos1, 32'h0, "locked axis idle");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        num_errors = 0;
        num_checks = 0;
        rst_b   = 1'b0;
        {resSel0, fmtSel0, resSel1, fmtSel1} = 16'h0;
        strobe  = 2'h0;
        rawPos0 = 32'h0;
        rawPos1 = 32'h0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        t_decode();
        t_locked();
        t_regs();
        t_fault();
        t_free();
        conclude();
    end
endmodule // absolute_encoder_axis_config_decode_tb
